// ==== logic/stdc_pkg.sv ====
/*
  Constants for the system tick down counter: register offsets, field positions,
  reset values and widths.
  Assumes an APB slave with 32-bit data and word-aligned byte addresses.
*/
`default_nettype none

package stdc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned CNT_W = 24;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_RELOAD = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CURRENT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CALIB = 4'hc;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h0;
  // Interrupt block in a second word group above the timer
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // Control/status field positions
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_EXC_BIT = 1;
  localparam int unsigned CTRL_CLKSEL_BIT = 2;
  localparam int unsigned CTRL_FLAG_BIT = 16;

  // Calibration field positions
  localparam int unsigned CAL_NO_EXTERNAL_REFERENCE_BIT = 31;
  localparam int unsigned CAL_INEXACT_BIT = 30;

  // Interrupt status field positions
  localparam int unsigned IRQ_ZERO_BIT = 0;
  localparam int unsigned IRQ_W = 1;

  // Reset values
  localparam logic [CNT_W-1:0] RELOAD_RST = 24'h000000;
  localparam logic [CNT_W-1:0] CURRENT_RST = 24'h000000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 1'h0;

  // Count clock select codes
  localparam logic CLKSEL_EXTERNAL = 1'h0;
  localparam logic CLKSEL_INTERNAL = 1'h1;
endpackage : stdc_pkg

`default_nettype wire

// ==== logic/stdc_tick_sel.sv ====
/*
  Count tick selection: turns the external reference tick into a one-cycle
  strobe on its rising edge, or passes the internal free-clock tick straight on.
  Assumes both tick inputs are synchronous to clock_i.
*/
`default_nettype none

module stdc_tick_sel (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Tick sources
  input wire logic external_reference_tick_i,
  input wire logic processor_free_clock_i,
  input wire logic count_clock_select_i,
  // Selected tick
  output logic tick_o
);
  import stdc_pkg::*;

  logic ext_prev_r;

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      // High after reset so an input already high gives no false edge
      ext_prev_r <= 1'b1;
    end else begin
      ext_prev_r <= external_reference_tick_i;
    end
  end

  // External ticks count on rising edges only
  always_comb begin
    if (count_clock_select_i == CLKSEL_INTERNAL) begin
      tick_o = processor_free_clock_i;
    end else begin
      tick_o = external_reference_tick_i & ~ext_prev_r;
    end
  end
endmodule // stdc_tick_sel

`default_nettype wire

// ==== logic/stdc_irq.sv ====
/*
  Sticky interrupt status with mask: events set bits, a status read clears them,
  and one level output is high while an unmasked bit is set.
  Assumes event and read-clear strobes are one-cycle pulses on clock_i.
*/
`default_nettype none

module stdc_irq #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Events and software access
  input wire logic [WIDTH-1:0] event_i,
  input wire logic status_read_i,
  input wire logic [WIDTH-1:0] mask_i,
  // State
  output logic [WIDTH-1:0] status_o,
  output logic irq_o
);
  logic [WIDTH-1:0] status_r;

  // Set wins over the read clear
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      status_r <= '0;
    end else if (status_read_i) begin
      status_r <= event_i;
    end else begin
      status_r <= status_r | event_i;
    end
  end

  assign status_o = status_r;
  assign irq_o = |(status_r & mask_i);
endmodule // stdc_irq

`default_nettype wire

// ==== logic/stdc_timer.sv ====
/*
  System tick down counter with an APB register port: control/status, reload,
  current value, calibration, plus an interrupt status and mask pair.
  Assumes an APB master on clock_i; tick inputs and calibration inputs are
  synchronous to clock_i; calibration inputs are static straps.
*/
`default_nettype none

// How it works
// - Counter runs only while control bit 0 is set; resets to zero.
// - Control bit 2 picks count clock: 0 external tick, 1 internal free clock.
// - On the tick after the count reaches zero, the 24-bit reload value is loaded into the count.
// - With control bit 1 set, reaching zero raises an exception request.
// - Control bit 16 reads 1 if zero was reached since the last control read.
// - Reading the control register returns the flag then clears it.
// - Current-value read returns the 24-bit count, upper bits zero.
// - Any current-value write clears the count and the zero-reached flag.
// - Calibration bit 31 reads 1 when no external reference tick exists.
// - Calibration bit 30 reads 1 when the ten-millisecond count is inexact.
// - Calibration bits 23:0 give the ticks in a ten-millisecond interval.
// - The ten-millisecond count comes from an input port, not software.

module stdc_timer #(
  parameter int unsigned CW = stdc_pkg::CNT_W
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Tick sources
  input wire logic external_reference_tick_i,
  input wire logic processor_free_clock_i,
  // Calibration inputs
  input wire logic no_external_reference_i,
  input wire logic calibration_inexact_i,
  input wire logic [stdc_pkg::CNT_W-1:0] ten_ms_count_i,
  // Requests
  output logic zero_exception_o,
  output logic irq_o
);
  import stdc_pkg::*;

  logic enable_r;
  logic zero_exception_enable_r;
  logic count_clock_select_r;
  logic zero_reached_flag_r;
  logic [CW-1:0] reload_r;
  logic [CW-1:0] current_r;
  logic [CW-1:0] current_nxt;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_status;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic tick;
  logic zero_event;
  logic wr_en;
  logic rd_en;
  logic ctrl_read;
  logic status_read;
  logic current_write;
  logic mapped;

  // APB answers in the first access cycle
  assign wr_en = psel_i & penable_i & pwrite_i;
  assign rd_en = psel_i & penable_i & ~pwrite_i;
  assign mapped = (paddr_i[7:2] <= 6'h05) && (paddr_i[1:0] == 2'b00);
  assign ctrl_read = rd_en && (paddr_i == {4'h0, OFS_CTRL});
  assign status_read = rd_en && (paddr_i == OFS_IRQ_STATUS);
  assign current_write = wr_en && (paddr_i == {4'h0, OFS_CURRENT});
  assign pready_o = 1'b1;
  assign prdata_o = prdata_r;
  assign pslverr_o = pslverr_r;

  stdc_tick_sel u_tick_sel (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .external_reference_tick_i(external_reference_tick_i),
    .processor_free_clock_i(processor_free_clock_i),
    .count_clock_select_i(count_clock_select_r),
    .tick_o(tick)
  );

  // Zero is reached on the tick that takes the count from one to zero
  assign zero_event = enable_r && tick && (current_r == CW'(1)) && !current_write;

  // Control register fields
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      enable_r <= 1'b0;
      zero_exception_enable_r <= 1'b0;
      count_clock_select_r <= CLKSEL_EXTERNAL;
    end else if (wr_en && paddr_i == {4'h0, OFS_CTRL}) begin
      enable_r <= pwdata_i[CTRL_ENABLE_BIT];
      zero_exception_enable_r <= pwdata_i[CTRL_EXC_BIT];
      count_clock_select_r <= pwdata_i[CTRL_CLKSEL_BIT];
    end
  end

  // Zero-reached flag: a new zero wins over the read clear
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      zero_reached_flag_r <= 1'b0;
    end else if (zero_event) begin
      zero_reached_flag_r <= 1'b1;
    end else if (ctrl_read || current_write) begin
      zero_reached_flag_r <= 1'b0;
    end
  end

  // Reload register
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      reload_r <= RELOAD_RST;
    end else if (wr_en && paddr_i == {4'h0, OFS_RELOAD}) begin
      reload_r <= pwdata_i[CW-1:0];
    end
  end

  // Down counter
  always_comb begin
    current_nxt = current_r;
    if (current_write) begin
      current_nxt = '0;
    end else if (enable_r && tick) begin
      if (current_r == '0) begin
        current_nxt = reload_r;
      end else begin
        current_nxt = current_r - CW'(1);
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      current_r <= CURRENT_RST;
    end else begin
      current_r <= current_nxt;
    end
  end

  // Exception request pulse, one cycle per zero
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      zero_exception_o <= 1'b0;
    end else begin
      zero_exception_o <= zero_event & zero_exception_enable_r;
    end
  end

  // Interrupt mask
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      irq_mask_r <= IRQ_MASK_RST;
    end else if (wr_en && paddr_i == OFS_IRQ_MASK) begin
      irq_mask_r <= pwdata_i[IRQ_W-1:0];
    end
  end

  stdc_irq #(
    .WIDTH(IRQ_W)
  ) u_irq (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .event_i(zero_event),
    .status_read_i(status_read),
    .mask_i(irq_mask_r),
    .status_o(irq_status),
    .irq_o(irq_o)
  );

  // Read data; the flag is sampled before its clear takes effect
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (psel_i && !penable_i) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= !mapped;
      if (!pwrite_i) begin
        case (paddr_i)
          {4'h0, OFS_CTRL}: begin
            prdata_r[CTRL_ENABLE_BIT] <= enable_r;
            prdata_r[CTRL_EXC_BIT] <= zero_exception_enable_r;
            prdata_r[CTRL_CLKSEL_BIT] <= count_clock_select_r;
            prdata_r[CTRL_FLAG_BIT] <= zero_reached_flag_r | zero_event;
          end
          {4'h0, OFS_RELOAD}: begin
            prdata_r[CW-1:0] <= reload_r;
          end
          {4'h0, OFS_CURRENT}: begin
            prdata_r[CW-1:0] <= current_nxt;
          end
          {4'h0, OFS_CALIB}: begin
            prdata_r[CAL_NO_EXTERNAL_REFERENCE_BIT] <= no_external_reference_i;
            prdata_r[CAL_INEXACT_BIT] <= calibration_inexact_i;
            prdata_r[CNT_W-1:0] <= ten_ms_count_i;
          end
          OFS_IRQ_STATUS: begin
            prdata_r[IRQ_W-1:0] <= irq_status | zero_event;
          end
          OFS_IRQ_MASK: begin
            prdata_r[IRQ_W-1:0] <= irq_mask_r;
          end
          default: begin
            prdata_r <= 32'h00000000;
          end
        endcase
      end
    end
  end
endmodule // stdc_timer

`default_nettype wire

// ==== test/stdc_timer_monitor.sv ====
/*
  Port checker for the system tick down counter, bound into stdc_timer.
  Assumes one clock and a synchronous active-low reset.
*/
`default_nettype none

module stdc_timer_monitor (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  // Calibration and requests
  input wire logic no_external_reference_i,
  input wire logic calibration_inexact_i,
  input wire logic [stdc_pkg::CNT_W-1:0] ten_ms_count_i,
  input wire logic zero_exception_o,
  input wire logic irq_o
);
  import stdc_pkg::*;
  logic [2:0] ctrl_r;
  logic mask_r;
  logic wr_acc, rd_set, bad;
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign rd_set = psel_i && !penable_i && !pwrite_i;
  assign bad = paddr_i[1:0] != 2'h0 || paddr_i > 8'h14;
  // Shadow of the written control bits and mask
  always_ff @(posedge clock_i) ctrl_r <= !rstn_i ? 3'h0 : (wr_acc && paddr_i == 8'h00 ? pwdata_i[2:0] : ctrl_r);
  always_ff @(posedge clock_i) mask_r <= rstn_i && (wr_acc && paddr_i == 8'h14 ? pwdata_i[0] : mask_r);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  a_calib_read: assert property (rd_set && paddr_i == 8'h0c |=>
    prdata_o == {no_external_reference_i, calibration_inexact_i, 6'h0, ten_ms_count_i}) else $error("calib word wrong");
  a_current_upper_zero: assert property (rd_set && paddr_i == 8'h08 |=> prdata_o[31:24] == 8'h0)
    else $error("current upper bits set");
  a_ctrl_readback: assert property (rd_set && paddr_i == 8'h00 |=> prdata_o[2:0] == ctrl_r
    && prdata_o[15:3] == 13'h0 && prdata_o[31:17] == 15'h0) else $error("control read wrong");
  a_exc_needs_enable: assert property (zero_exception_o |-> ctrl_r[1] || $past(ctrl_r[1]))
    else $error("exception while disabled");
  a_exc_one_pulse: assert property (zero_exception_o |=> !zero_exception_o) else $error("exception too long");
  a_irq_masked: assert property (irq_o |-> mask_r) else $error("irq while masked");
  a_unmapped_err: assert property (psel_i && !penable_i && bad |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel_i && !penable_i && !bad |=> !pslverr_o) else $error("mapped access refused");
  a_reset_quiet: assert property (disable iff (1'b0) !rstn_i |=> !zero_exception_o && !irq_o)
    else $error("request during reset");
endmodule // stdc_timer_monitor

bind stdc_timer stdc_timer_monitor i_stdc_timer_monitor (.clock_i, .rstn_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .prdata_o, .pslverr_o, .no_external_reference_i, .calibration_inexact_i,
  .ten_ms_count_i, .zero_exception_o, .irq_o);

`default_nettype wire

// ==== test/testbench.sv ====
/*
  Self-checking bench for stdc_timer: APB tasks, tick drive and a count model.
  Assumes the design package and one 40 MHz clock.
*/
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; $display("Error %s exp %h got %h", nm, e, g); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import stdc_pkg::*;
  logic clock_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, ext_tick = 0, free_tick = 0;
  logic [7:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic pready_o, pslverr_o, err, zero_exception_o, irq_o, no_external_reference, inexact;
  logic [23:0] ten_ms, cnt;
  int seed = 32'h07cb, n_errors = 0, compares = 0, n_exc = 0, zeros, r, k, k2;

  stdc_timer i_stdc_timer (.clock_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .external_reference_tick_i(ext_tick), .processor_free_clock_i(free_tick),
    .no_external_reference_i(no_external_reference), .calibration_inexact_i(inexact), .ten_ms_count_i(ten_ms),
    .zero_exception_o, .irq_o);

  initial begin
    forever #12.5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) if (zero_exception_o === 1'b1) n_exc++;

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 0; penable_i <= 0;
    @(posedge clock_i);
  endtask

  // External edges n times; the free tick stays high throughout (2n ticks)
  task automatic ticks(input int n);
    repeat (n) begin
      ext_tick <= 1; free_tick <= 1; @(posedge clock_i);
      ext_tick <= 0; @(posedge clock_i);
    end
    free_tick <= 0;
    repeat (4) @(posedge clock_i);
  endtask

  task automatic model(input int n);
    repeat (n) begin
      if (cnt == 0) cnt = r[23:0];
      else begin cnt--; if (cnt == 0) zeros++; end
    end
  endtask

  task automatic report_and_stop;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    r = $random(seed);
    no_external_reference = r[31];
    inexact = r[30];
    ten_ms = r[23:0];
    repeat (4) @(posedge clock_i);
    rstn_i <= 1;
    @(posedge clock_i);
    for (int a = 0; a < 24; a += 4) begin
      apb(0, a[7:0], 0);
      if (a != 12) `CHK("reset value", 32'h0, rd)
      else `CHK("calib", {no_external_reference, inexact, 6'h0, ten_ms}, rd)
      `CHK("slave error", 1'b0, err)
    end
    apb(1, 8'h18, 32'hffffffff); `CHK("unmapped", 1'b1, err)
    apb(1, 8'h06, 32'hffffffff); `CHK("unaligned", 1'b1, err)
    for (int i = 0; i < 4; i++) begin
      // Mask off on the last pass so a set status must not raise the level
      apb(1, 8'h14, {31'h0, i != 3});
      r = ($random(seed) & 7) + 1;
      k = i == 0 ? 16 : ($random(seed) & 15) + 1;
      k2 = i[1] ? 2 * k : k;
      apb(1, 8'h04, r); apb(1, 8'h00, {29'h0, i[1:0], 1'b1});
      n_exc = 0; zeros = 0; cnt = 0;
      model(k2); ticks(k);
      apb(0, 8'h08, 0); `CHK("count", {8'h0, cnt}, rd)
      apb(0, 8'h00, 0); `CHK("control", {15'h0, zeros != 0, 13'h0, i[1:0], 1'b1}, rd)
      apb(0, 8'h00, 0); `CHK("flag read clear", 1'b0, rd[16])
      model(k2); ticks(k);
      apb(1, 8'h08, $random(seed)); apb(0, 8'h00, 0); `CHK("flag write clear", 1'b0, rd[16])
      apb(0, 8'h08, 0); `CHK("count write clear", 32'h0, rd)
      `CHK("exceptions", i[0] ? zeros : 0, n_exc)
      `CHK("irq level", zeros != 0 && i != 3, irq_o)
      apb(0, 8'h10, 0); `CHK("irq status", zeros != 0, rd[0])
      `CHK("irq cleared", 1'b0, irq_o)
      apb(1, 8'h00, {29'h0, i[1:0], 1'b0}); ticks(1);
      apb(0, 8'h08, 0); `CHK("count held", 32'h0, rd)
    end
    // Software view: a zero ten-millisecond count marks calibration unusable
    ten_ms <= 24'h000000;
    @(posedge clock_i);
    apb(0, 8'h0c, 0); `CHK("calib usable", 1'b0, rd[23:0] != 24'h000000)
    report_and_stop;
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    n_errors++;
    report_and_stop;
  end
endmodule // testbench

`default_nettype wire
